// ==== hw/arf_consts.svh ====
`ifndef ARF_CONSTS_SVH
`define ARF_CONSTS_SVH

// Register byte addresses.
`define ARF_OFF_ASYNC_HI_SET 12'h100
`define ARF_OFF_ASYNC_HI_CLR 12'h104
`define ARF_OFF_ASYNC_LO_SET 12'h108
`define ARF_OFF_ASYNC_LO_CLR 12'h10C
`define ARF_OFF_PHYS_HI_SET  12'h110
`define ARF_OFF_PHYS_HI_CLR  12'h114
`define ARF_OFF_PHYS_LO_SET  12'h118
`define ARF_OFF_PHYS_LO_CLR  12'h11C
`define ARF_OFF_FILTER_STAT  12'h120

// Reset values.
`define ARF_FILTER_RESET     32'h0000_0000
`define ARF_STAT_RESET       16'h0000

// Field positions, masks and special values.
`define ARF_ALL_REMOTE_BIT   5'h1F
`define ARF_HIGH_NODE_BIT    5
`define ARF_HI_KEEP_MASK     32'h8000_0000
`define ARF_LO_KEEP_MASK     32'h0000_0000
`define ARF_BROADCAST_NODE   6'h3F
`define ARF_LOCAL_BUS_ALIAS  10'h3FF
`define ARF_CNT_MAX          16'hFFFF

`endif

// ==== hw/arf_pkg.sv ====
`default_nettype none
package arf_pkg;

  typedef struct packed {
    logic [9:0] bus_num;
    logic [5:0] node_num;
  } arf_src_id_s;

  typedef enum logic [1:0] {
    ARF_ROUTE_DROP,
    ARF_ROUTE_PHYS,
    ARF_ROUTE_ASYNC_RX_REQUEST_CONTEXT
  } arf_route_e;

  typedef logic [31:0] arf_word_t;

endpackage
`default_nettype wire

// ==== hw/arf_reg_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface arf_reg_if;
  logic        set_we;
  logic        clr_we;
  logic [31:0] wmask;
  logic        bus_reset;
  logic        lock;
  logic [31:0] keep_mask;
  logic [31:0] value;

  modport ctrl (
    output set_we,
    output clr_we,
    output wmask,
    output bus_reset,
    output lock,
    output keep_mask,
    input  value
  );

  modport store (
    input  set_we,
    input  clr_we,
    input  wmask,
    input  bus_reset,
    input  lock,
    input  keep_mask,
    output value
  );
endinterface
`default_nettype wire

// ==== hw/arf_filter_reg.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "arf_consts.svh"
module arf_filter_reg
  import arf_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  arf_reg_if.store   rif
);

  arf_word_t value_ff;
  arf_word_t nxt_value;

  // Bus reset outranks a software access in the same cycle; the lock is
  // normally up then anyway because the event flag rises with the reset.
  always_comb begin
    nxt_value = value_ff;
    if (rif.bus_reset) begin
      nxt_value = value_ff & rif.keep_mask; // (R9) (R10)
    end else if (rif.set_we && !rif.lock) begin
      nxt_value = value_ff | rif.wmask; // (R17) (R8)
    end else if (rif.clr_we && !rif.lock) begin
      nxt_value = value_ff & ~rif.wmask; // (R17) (R8)
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_ff <= `ARF_FILTER_RESET; // (R18)
    end else begin
      value_ff <= nxt_value;
    end
  end

  assign rif.value = value_ff;

endmodule
`default_nettype wire

// ==== hw/arf_top.sv ====
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "arf_consts.svh"
// Summary of operation
// (R1) Check source node of physical/ASYNC_RX_REQUEST_CONTEXT-bound requests.
// (R2) Clear node bit: no ack, no queue.
// (R3) Per-node bits only for local-bus sources.
// (R4) Remote sources unacknowledged unless async bit31.
// (R5) Async bit31 accepts all remote requests.
// (R6) Async high bits 30:0 cover nodes 32-62.
// (R7) Async low bits 31:0 cover nodes 0-31.
// (R8) Filter writes ignored while bus-reset flag set.
// (R9) Bus reset clears all per-node bits.
// (R10) Bus reset keeps both bit31 values.
// (R11) Physical bit clear sends request to ASYNC_RX_REQUEST_CONTEXT.
// (R12) Physical bit31 routes remote requests physically.
// (R13) Physical high bits 30:0 cover nodes 32-62.
// (R14) Physical low bits 31:0 cover nodes 0-31.
// (R15) Local bus number is ten bits wide.
// (R16) Node numbers are six bits wide.
// (R17) Write ones sets or clears; zeros ignored.
// (R18) Either address reads value; reset zero.
module arf_top
  import arf_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        BUS_RESET,
  input  wire logic        BUS_RESET_EVENT,
  input  wire logic [9:0]  LOCAL_BUS_NUMBER,
  input  wire logic        REQ_VALID,
  input  wire logic        REQ_TO_PHYS,
  input  wire logic [15:0] REQ_SRC_ID,
  output logic             RESP_VALID,
  output logic             RESP_ACK,
  output logic             RESP_TO_PHYS,
  output logic             RESP_TO_ASYNC_RX_REQUEST_CONTEXT
);

  localparam int NREG = 4;

  // ---------------------------------------------------------------------
  // APB address decode.
  // ---------------------------------------------------------------------
  wire        hit_ahs = (PADDR == `ARF_OFF_ASYNC_HI_SET);
  wire        hit_ahc = (PADDR == `ARF_OFF_ASYNC_HI_CLR);
  wire        hit_als = (PADDR == `ARF_OFF_ASYNC_LO_SET);
  wire        hit_alc = (PADDR == `ARF_OFF_ASYNC_LO_CLR);
  wire        hit_phs = (PADDR == `ARF_OFF_PHYS_HI_SET);
  wire        hit_phc = (PADDR == `ARF_OFF_PHYS_HI_CLR);
  wire        hit_pls = (PADDR == `ARF_OFF_PHYS_LO_SET);
  wire        hit_plc = (PADDR == `ARF_OFF_PHYS_LO_CLR);
  wire        hit_sta = (PADDR == `ARF_OFF_FILTER_STAT);

  // Index 0 async high, 1 async low, 2 physical high, 3 physical low.
  wire [NREG-1:0] set_hit = {hit_pls, hit_phs, hit_als, hit_ahs};
  wire [NREG-1:0] clr_hit = {hit_plc, hit_phc, hit_alc, hit_ahc};
  wire [NREG-1:0] pair_hit = set_hit | clr_hit;
  wire            hit_any = (|pair_hit) | hit_sta;

  wire access = PSEL && PENABLE;
  wire wr_go  = access && PWRITE;
  wire rd_setup = PSEL && !PENABLE && !PWRITE;

  wire [31:0] byte_mask = {{8{PSTRB[3]}}, {8{PSTRB[2]}},
                           {8{PSTRB[1]}}, {8{PSTRB[0]}}};
  wire [31:0] wr_mask = PWDATA & byte_mask;

  // Zero-wait slave: every access completes in its first access cycle.
  assign PREADY  = 1'b1;
  assign PSLVERR = access && !hit_any;

  // ---------------------------------------------------------------------
  // Filter registers.
  // ---------------------------------------------------------------------
  arf_reg_if rif [NREG] ();

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1) begin : g_filt
      assign rif[gi].set_we    = wr_go && set_hit[gi]; // (R17)
      assign rif[gi].clr_we    = wr_go && clr_hit[gi]; // (R17)
      assign rif[gi].wmask     = wr_mask;
      assign rif[gi].bus_reset = BUS_RESET; // (R9)
      assign rif[gi].lock      = BUS_RESET_EVENT; // (R8)
      assign rif[gi].keep_mask = (gi % 2 == 0) ? `ARF_HI_KEEP_MASK
                                               : `ARF_LO_KEEP_MASK; // (R10)

      arf_filter_reg u_reg (
        .clk   (REF_CLK),
        .rst_n (RESET_N),
        .rif   (rif[gi])
      );
    end
  endgenerate

  wire arf_word_t async_hi = rif[0].value;
  wire arf_word_t async_lo = rif[1].value;
  wire arf_word_t phys_hi  = rif[2].value;
  wire arf_word_t phys_lo  = rif[3].value;

  // ---------------------------------------------------------------------
  // Request lookup.
  // ---------------------------------------------------------------------
  wire arf_src_id_s src = arf_src_id_s'(REQ_SRC_ID); // (R15) (R16)

  // The all-ones bus number always names the local bus.
  wire src_local = (src.bus_num == LOCAL_BUS_NUMBER) ||
                   (src.bus_num == `ARF_LOCAL_BUS_ALIAS); // (R3) (R15)

  wire       node_high = src.node_num[`ARF_HIGH_NODE_BIT]; // (R16)
  wire [4:0] node_bit  = src.node_num[4:0];
  // Node 63 would land on the all-remote bit, so it never matches a node.
  wire       node_bcast = (src.node_num == `ARF_BROADCAST_NODE);

  wire async_node_ok = node_bcast ? 1'b0 :
                       node_high  ? async_hi[node_bit] // (R6)
                                  : async_lo[node_bit]; // (R7)
  wire phys_node_ok  = node_bcast ? 1'b0 :
                       node_high  ? phys_hi[node_bit] // (R13)
                                  : phys_lo[node_bit]; // (R14)

  wire async_remote_ok = async_hi[`ARF_ALL_REMOTE_BIT]; // (R4) (R5)
  wire phys_remote_ok  = phys_hi[`ARF_ALL_REMOTE_BIT]; // (R12)

  wire accept  = src_local ? async_node_ok : async_remote_ok; // (R1) (R2) (R3) (R5)
  wire phys_ok = src_local ? phys_node_ok : phys_remote_ok; // (R11) (R12)

  arf_route_e route;
  always_comb begin
    if (!accept) begin
      route = ARF_ROUTE_DROP; // (R2) (R4)
    end else if (REQ_TO_PHYS && phys_ok) begin
      route = ARF_ROUTE_PHYS; // (R11)
    end else begin
      route = ARF_ROUTE_ASYNC_RX_REQUEST_CONTEXT; // (R11)
    end
  end

  logic resp_valid_ff;
  logic resp_ack_ff;
  logic resp_phys_ff;
  logic resp_async_rx_request_context_ff;
  logic nxt_resp_ack;
  logic nxt_resp_phys;
  logic nxt_resp_async_rx_request_context;

  assign nxt_resp_ack  = REQ_VALID && (route != ARF_ROUTE_DROP); // (R2)
  assign nxt_resp_phys = REQ_VALID && (route == ARF_ROUTE_PHYS);
  assign nxt_resp_async_rx_request_context = REQ_VALID && (route == ARF_ROUTE_ASYNC_RX_REQUEST_CONTEXT);

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      resp_valid_ff <= 1'b0;
      resp_ack_ff   <= 1'b0;
      resp_phys_ff  <= 1'b0;
      resp_async_rx_request_context_ff  <= 1'b0;
    end else begin
      resp_valid_ff <= REQ_VALID;
      resp_ack_ff   <= nxt_resp_ack;
      resp_phys_ff  <= nxt_resp_phys;
      resp_async_rx_request_context_ff  <= nxt_resp_async_rx_request_context;
    end
  end

  assign RESP_VALID   = resp_valid_ff;
  assign RESP_ACK     = resp_ack_ff;
  assign RESP_TO_PHYS = resp_phys_ff;
  assign RESP_TO_ASYNC_RX_REQUEST_CONTEXT = resp_async_rx_request_context_ff;

  // ---------------------------------------------------------------------
  // Filter statistics: requests dropped and physical requests that fell
  // back to the request context. Counters saturate rather than wrap so a
  // long run never reports a misleadingly small number.
  // ---------------------------------------------------------------------
  logic [15:0] cnt_drop_ff;
  logic [15:0] cnt_fall_ff;
  logic [15:0] nxt_cnt_drop;
  logic [15:0] nxt_cnt_fall;

  wire stat_clr = wr_go && hit_sta;
  wire ev_drop  = REQ_VALID && (route == ARF_ROUTE_DROP);
  wire ev_fall  = REQ_VALID && REQ_TO_PHYS && (route == ARF_ROUTE_ASYNC_RX_REQUEST_CONTEXT);

  // A clear in the same cycle as an event leaves that event counted.
  always_comb begin
    nxt_cnt_drop = stat_clr ? `ARF_STAT_RESET : cnt_drop_ff;
    nxt_cnt_fall = stat_clr ? `ARF_STAT_RESET : cnt_fall_ff;
    if (ev_drop && nxt_cnt_drop != `ARF_CNT_MAX) begin
      nxt_cnt_drop = nxt_cnt_drop + 16'h0001;
    end
    if (ev_fall && nxt_cnt_fall != `ARF_CNT_MAX) begin
      nxt_cnt_fall = nxt_cnt_fall + 16'h0001;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cnt_drop_ff <= `ARF_STAT_RESET;
      cnt_fall_ff <= `ARF_STAT_RESET;
    end else begin
      cnt_drop_ff <= nxt_cnt_drop;
      cnt_fall_ff <= nxt_cnt_fall;
    end
  end

  // ---------------------------------------------------------------------
  // Read path. Data is captured in the setup cycle so PRDATA comes from a
  // flop; a bus reset landing between setup and access is seen on the
  // next read only.
  // ---------------------------------------------------------------------
  wire [31:0] rd_mux =
    (pair_hit[0]) ? async_hi : // (R18)
    (pair_hit[1]) ? async_lo : // (R18)
    (pair_hit[2]) ? phys_hi  : // (R18)
    (pair_hit[3]) ? phys_lo  : // (R18)
    (hit_sta)     ? {cnt_fall_ff, cnt_drop_ff} :
                    32'h0000_0000;

  logic [31:0] prdata_ff;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_ff <= rd_mux;
    end
  end

  assign PRDATA = prdata_ff;

endmodule
`default_nettype wire

// ==== dv/arf_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module arf_top_asserts (
  input wire logic        REF_CLK,
  input wire logic        RESET_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic        PSLVERR,
  input wire logic        REQ_VALID,
  input wire logic        REQ_TO_PHYS,
  input wire logic        RESP_VALID,
  input wire logic        RESP_ACK,
  input wire logic        RESP_TO_PHYS,
  input wire logic        RESP_TO_ASYNC_RX_REQUEST_CONTEXT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  property p_lat; REQ_VALID |=> RESP_VALID; endproperty
  a_lat: assert property (p_lat) else $error("no answer");
  property p_idle; !REQ_VALID |=> !RESP_VALID; endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_drop; RESP_VALID && !RESP_ACK |-> !RESP_TO_PHYS && !RESP_TO_ASYNC_RX_REQUEST_CONTEXT; endproperty
  a_drop: assert property (p_drop) else $error("dropped but routed");
  property p_quiet; !RESP_VALID |-> !(RESP_ACK || RESP_TO_PHYS || RESP_TO_ASYNC_RX_REQUEST_CONTEXT); endproperty
  a_quiet: assert property (p_quiet) else $error("result without answer");
  property p_one; RESP_VALID && RESP_ACK |-> RESP_TO_PHYS != RESP_TO_ASYNC_RX_REQUEST_CONTEXT; endproperty
  a_one: assert property (p_one) else $error("accepted but not one route");
  property p_async_rx_request_context; REQ_VALID && !REQ_TO_PHYS |=> !RESP_TO_PHYS; endproperty
  a_async_rx_request_context: assert property (p_async_rx_request_context) else $error("async request routed physically");
  property p_phys; RESP_TO_PHYS |-> $past(REQ_TO_PHYS) && RESP_ACK; endproperty
  a_phys: assert property (p_phys) else $error("physical route without cause");
  property p_map; PSEL && PENABLE && PADDR[11:5] == 7'h08 && PADDR[1:0] == 2'b00 |-> !PSLVERR;
  endproperty
  a_map: assert property (p_map) else $error("filter address refused");
  c_phys: cover property (RESP_TO_PHYS);
  c_async_rx_request_context: cover property (RESP_TO_ASYNC_RX_REQUEST_CONTEXT);
  c_drop: cover property (RESP_VALID && !RESP_ACK);
endmodule
bind arf_top arf_top_asserts chk_u (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PADDR(PADDR), .PSLVERR(PSLVERR), .REQ_VALID(REQ_VALID),
  .REQ_TO_PHYS(REQ_TO_PHYS), .RESP_VALID(RESP_VALID), .RESP_ACK(RESP_ACK),
  .RESP_TO_PHYS(RESP_TO_PHYS), .RESP_TO_ASYNC_RX_REQUEST_CONTEXT(RESP_TO_ASYNC_RX_REQUEST_CONTEXT));
`default_nettype wire

// ==== dv/arf_node_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module arf_node_model (
  input  wire logic   clk,
  output logic        req_valid,
  output logic        req_to_phys,
  output logic [15:0] req_src_id
);
  initial begin
    req_valid = 1'b0;
    req_to_phys = 1'b0;
    req_src_id = 16'h0000;
  end
  // Between requests the source id is inverted so a stale value never looks valid.
  task automatic send(input logic [15:0] s, input logic ph);
    @(posedge clk);
    req_valid <= 1'b1;
    req_to_phys <= ph;
    req_src_id <= s;
    @(posedge clk);
    req_valid <= 1'b0;
    req_src_id <= ~s;
  endtask
endmodule
`default_nettype wire

// ==== dv/async_physical_request_filter_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module async_physical_request_filter_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0000_0000;
  logic [3:0]  pstb = 4'hF;
  logic        bres = 1'b0;
  logic        bevt = 1'b0;
  logic [9:0]  lbus = 10'h005;
  logic [31:0] prd;
  logic        prdy;
  logic        perr;
  logic        rv;
  logic        rack;
  logic        rph;
  logic        rarq;
  logic        qv;
  logic        qp;
  logic [15:0] qs;
  logic [31:0] rdat;
  logic        rerr;
  int          errors = 0;
  int          tests_run = 0;

  always #12.5 clk = ~clk;

  arf_top dut_u (.REF_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(padr), .PWDATA(pwd), .PSTRB(pstb), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .BUS_RESET(bres), .BUS_RESET_EVENT(bevt), .LOCAL_BUS_NUMBER(lbus), .REQ_VALID(qv),
    .REQ_TO_PHYS(qp), .REQ_SRC_ID(qs), .RESP_VALID(rv), .RESP_ACK(rack),
    .RESP_TO_PHYS(rph), .RESP_TO_ASYNC_RX_REQUEST_CONTEXT(rarq));
  arf_node_model nm (.clk(clk), .req_valid(qv), .req_to_phys(qp), .req_src_id(qs));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait in which the slave never answers.
    while (prdy !== 1'b1) begin
      @(posedge clk);
    end
    rdat = prd;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic req(input logic [15:0] s, input logic ph, input logic [2:0] e);
    nm.send(s, ph);
    #1;
    chk({28'h0, rv, rack, rph, rarq}, {28'h1, e});
  endtask

  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'h100 + 12'(4 * i), 32'h0000_0000);
      chk(rdat, 32'h0000_0000);
    end
    apb(1'b0, 12'h200, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001);
  endtask

  task automatic t_setclr;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h100 + 12'(8 * i), 32'hFFFF_FFFF);
      apb(1'b0, 12'h104 + 12'(8 * i), 32'h0000_0000);
      chk(rdat, 32'hFFFF_FFFF);
      apb(1'b1, 12'h104 + 12'(8 * i), 32'h0000_00F0);
      apb(1'b0, 12'h100 + 12'(8 * i), 32'h0000_0000);
      chk(rdat, 32'hFFFF_FF0F);
      apb(1'b1, 12'h104 + 12'(8 * i), 32'hFFFF_FFFF);
    end
  endtask

  // Outcome code is accept, physical route, fallback route.
  task automatic t_route;
    apb(1'b1, 12'h100, 32'h0000_0001);
    apb(1'b1, 12'h108, 32'h0000_0020);
    apb(1'b1, 12'h118, 32'h0000_0020);
    req({10'h005, 6'd5}, 1'b1, 3'b110);
    req({10'h005, 6'd5}, 1'b0, 3'b101);
    req({10'h005, 6'd32}, 1'b1, 3'b101);
    req({10'h005, 6'd6}, 1'b1, 3'b000);
    req({10'h001, 6'd5}, 1'b1, 3'b000);
    apb(1'b1, 12'h100, 32'h8000_0000);
    req({10'h001, 6'd6}, 1'b1, 3'b101);
    apb(1'b1, 12'h110, 32'h8000_0001);
    req({10'h001, 6'd6}, 1'b1, 3'b110);
    req({10'h005, 6'd32}, 1'b1, 3'b110);
    req({10'h005, 6'd5}, 1'b1, 3'b110);
    req({10'h3FF, 6'd5}, 1'b0, 3'b101);
    // Two drops and two physical fallbacks were sent above.
    apb(1'b0, 12'h120, 32'h0000_0000);
    chk(rdat, 32'h0002_0002);
    apb(1'b1, 12'h120, 32'h0000_0000);
    apb(1'b0, 12'h120, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
  endtask

  task automatic t_busrst;
    @(posedge clk);
    bres <= 1'b1;
    @(posedge clk);
    bres <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'h100 + 12'(8 * i), 32'h0000_0000);
      chk(rdat, i[0] ? 32'h0000_0000 : 32'h8000_0000);
    end
  endtask

  task automatic t_lock;
    @(posedge clk);
    bevt <= 1'b1;
    apb(1'b1, 12'h108, 32'h0000_000F);
    apb(1'b1, 12'h104, 32'h8000_0000);
    bevt <= 1'b0;
    apb(1'b0, 12'h108, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk(rdat, 32'h8000_0000);
    // Bytes whose strobe is low must leave their bits alone.
    @(posedge clk);
    pstb <= 4'h5;
    apb(1'b1, 12'h118, 32'hFFFF_FFFF);
    pstb <= 4'hF;
    apb(1'b0, 12'h11C, 32'h0000_0000);
    chk(rdat, 32'h00FF_00FF);
  endtask

  task automatic final_report;
    $display("comparisons %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_setclr;
    t_route;
    t_busrst;
    t_lock;
    final_report;
  end

  initial begin
    #200000;
    errors++;
    final_report;
  end
endmodule
`default_nettype wire
